/* ivm_params.svh */
// Constants for the interrupt vector map: widths, counts and slot offsets.
// Assumes the includer wants plain text macros; no logic lives here.
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH

// Widths and counts.
`define IVM_ADDR_W 24
`define IVM_NUM_SRC 44
`define IVM_NUM_L3 5
`define IVM_IDX_W 6
`define IVM_BOOT_IDX 6'h05

// Level-3 slots.
`define OFF_RESET 8'h00
`define OFF_STACK 8'h02
`define OFF_ILLEGAL 8'h04
`define OFF_DEBUG 8'h06
`define OFF_TRAP 8'h08
`define OFF_NMI 8'h0a
`define OFF_L3_RSV_A 8'h0c
`define OFF_L3_RSV_B 8'h0e

// Pins and transfer channels; channel n sits at OFF_DMA0 plus two n.
`define OFF_EXT_A 8'h10
`define OFF_EXT_B 8'h12
`define OFF_EXT_C 8'h14
`define OFF_EXT_D 8'h16
`define OFF_DMA0 8'h18

// Digital audio transmitter.
`define OFF_DAX_UND 8'h28
`define OFF_DAX_BLK 8'h2a
`define OFF_DAX_RSV 8'h2c
`define OFF_DAX_EMPTY 8'h2e

// First audio port.
`define OFF_A0_RXD 8'h30
`define OFF_A0_RXE 8'h32
`define OFF_A0_RXX 8'h34
`define OFF_A0_RXL 8'h36
`define OFF_A0_TXD 8'h38
`define OFF_A0_TXE 8'h3a
`define OFF_A0_TXX 8'h3c
`define OFF_A0_TXL 8'h3e

// Serial host port.
`define OFF_SHP_TXD 8'h40
`define OFF_SHP_TXU 8'h42
`define OFF_SHP_RNE 8'h44
`define OFF_SHP_RSV 8'h46
`define OFF_SHP_RFF 8'h48
`define OFF_SHP_ROV 8'h4a
`define OFF_SHP_BUS 8'h4c

// Counters.
`define OFF_C0_CMP 8'h54
`define OFF_C0_OVF 8'h56
`define OFF_C1_CMP 8'h58
`define OFF_C1_OVF 8'h5a
`define OFF_C2_CMP 8'h5c
`define OFF_C2_OVF 8'h5e

// Parallel host port.
`define OFF_PHP_RXF 8'h60
`define OFF_PHP_TXE 8'h62
`define OFF_PHP_CMD 8'h64

// Second audio port.
`define OFF_A1_RXD 8'h70
`define OFF_A1_RXE 8'h72
`define OFF_A1_RXX 8'h74
`define OFF_A1_RXL 8'h76
`define OFF_A1_TXD 8'h78
`define OFF_A1_TXE 8'h7a
`define OFF_A1_TXX 8'h7c
`define OFF_A1_TXL 8'h7e

// Reserved ranges.
`define OFF_RSV_A 8'h24
`define OFF_RSV_B 8'h26
`define OFF_RSV_LO 8'h4e
`define OFF_RSV_HI 8'h52
`define OFF_RSV2_LO 8'h66
`define OFF_RSV2_HI 8'h6e
`define OFF_RSV_TOP 8'h80

`endif

/* ivm_pkg.sv */
// Types shared by the interrupt vector map.
// Assumes ivm_params.svh is on the include path.
`default_nettype none
`include "ivm_params.svh"

package ivm_pkg;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_OFFER, ST_ACK} ivm_state_e;

  typedef struct packed {
    logic valid;
    logic [`IVM_ADDR_W-1:0] addr;
    logic [1:0] level;
    logic level3;
    logic [`IVM_IDX_W-1:0] source;
  } vector_offer_s;

  typedef struct packed {
    ivm_state_e state;
    vector_offer_s offer;
    logic [`IVM_NUM_SRC-1:0] ack;
    logic [`IVM_NUM_L3-1:0] l3_ack;
    logic [1:0] pend_level;
    logic pend_any;
  } ivm_regs_s;

endpackage

`default_nettype wire

/* interrupt_vector_map.sv */
// Interrupt vector map: arbitrates pending sources and offers the
// sequencer one vector address at a time, then acknowledges the source.
// Assumes requests and the vector base are synchronous to clk and that a
// source drops its request on the edge at which its acknowledge is high.
`timescale 1ns/1ps
`default_nettype none
`include "ivm_params.svh"

// Contract
// - Level-3 slots fixed, never dispatch 0C/0E.
// - First port receive vectors 30 to 36.
// - First port transmit vectors 38 to 3E.
// - Second port receive vectors 70 to 76.
// - Second port transmit vectors 78 to 7E.
// - Serial host transmit 40, underrun 42.
// - Serial host not-empty 44, full 48.
// - Serial host overrun 4A, bus error 4C.
// - Parallel host receive full 60.
// - Parallel host transmit 62, command 64.
// - Audio transmitter 28, 2A, 2E; 2C reserved.
// - Two-bit field: 00 off, else levels 0-2.
// - Same level served in fixed source order.
module interrupt_vector_map (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Vector base and the sequencer's current mask level.
  input wire logic [`IVM_ADDR_W-1:0] vector_base,
  input wire logic [1:0] core_mask,
  // Level-3 requests, bit 0 is the highest.
  input wire logic [`IVM_NUM_L3-1:0] level3_req,
  // Maskable requests in service order and their level fields.
  input wire logic [`IVM_NUM_SRC-1:0] source_req,
  input wire logic [`IVM_NUM_SRC-1:0][1:0] priority_level,
  // Vector offer and its handshake.
  output var ivm_pkg::vector_offer_s vector_offer,
  input wire logic vector_taken,
  // Acknowledges and pending summary.
  output logic [`IVM_NUM_SRC-1:0] source_ack,
  output logic [`IVM_NUM_L3-1:0] level3_ack,
  output logic [1:0] pending_level,
  output logic pending_any
);

  ivm_pkg::ivm_regs_s r;
  ivm_pkg::ivm_regs_s next_r;

  logic [1:0] best_field;
  logic sel_found;
  logic [`IVM_IDX_W-1:0] sel_idx;
  logic l3_found;
  logic [`IVM_IDX_W-1:0] l3_idx;
  logic maskable_ok;
  logic still_pending;
  logic [1:0] pend_code;

  // Slot of each maskable source, indexed in service order.
  function automatic logic [7:0] maskable_offset(input logic [`IVM_IDX_W-1:0] idx);
    case (idx)
      // External request pins come first in service order.
      6'd0: maskable_offset = `OFF_EXT_A;
      6'd1: maskable_offset = `OFF_EXT_B;
      6'd2: maskable_offset = `OFF_EXT_C;
      6'd3: maskable_offset = `OFF_EXT_D;
      // Transfer channels sit in consecutive slots after the pins.
      6'd4, 6'd5, 6'd6, 6'd7, 6'd8, 6'd9: begin
        maskable_offset = 8'(`OFF_DMA0 + {idx[5:0] - 6'd4, 1'b0});
      end
      // First audio port, receive before transmit.
      6'd10: maskable_offset = `OFF_A0_RXX;
      6'd11: maskable_offset = `OFF_A0_RXE;
      6'd12: maskable_offset = `OFF_A0_RXD;
      6'd13: maskable_offset = `OFF_A0_RXL;
      6'd14: maskable_offset = `OFF_A0_TXX;
      6'd15: maskable_offset = `OFF_A0_TXL;
      6'd16: maskable_offset = `OFF_A0_TXE;
      6'd17: maskable_offset = `OFF_A0_TXD;
      // Serial host port; the slot between its queue requests stays empty.
      6'd18: maskable_offset = `OFF_SHP_BUS;
      6'd19: maskable_offset = `OFF_SHP_ROV;
      6'd20: maskable_offset = `OFF_SHP_TXU;
      6'd21: maskable_offset = `OFF_SHP_RFF;
      6'd22: maskable_offset = `OFF_SHP_TXD;
      6'd23: maskable_offset = `OFF_SHP_RNE;
      // Parallel host port, command first.
      6'd24: maskable_offset = `OFF_PHP_CMD;
      6'd25: maskable_offset = `OFF_PHP_RXF;
      6'd26: maskable_offset = `OFF_PHP_TXE;
      // Digital audio transmitter; its third slot has no source.
      6'd27: maskable_offset = `OFF_DAX_UND;
      6'd28: maskable_offset = `OFF_DAX_BLK;
      6'd29: maskable_offset = `OFF_DAX_EMPTY;
      // Counters, overflow ahead of compare in service order.
      6'd30: maskable_offset = `OFF_C0_OVF;
      6'd31: maskable_offset = `OFF_C0_CMP;
      6'd32: maskable_offset = `OFF_C1_OVF;
      6'd33: maskable_offset = `OFF_C1_CMP;
      6'd34: maskable_offset = `OFF_C2_OVF;
      6'd35: maskable_offset = `OFF_C2_CMP;
      // Second audio port, lowest in service order.
      6'd36: maskable_offset = `OFF_A1_RXX;
      6'd37: maskable_offset = `OFF_A1_RXE;
      6'd38: maskable_offset = `OFF_A1_RXD;
      6'd39: maskable_offset = `OFF_A1_RXL;
      6'd40: maskable_offset = `OFF_A1_TXX;
      6'd41: maskable_offset = `OFF_A1_TXL;
      6'd42: maskable_offset = `OFF_A1_TXE;
      6'd43: maskable_offset = `OFF_A1_TXD;
      // Indices past the table land on a reserved slot, which is refused.
      default: maskable_offset = `OFF_RSV_TOP;
    endcase
  endfunction

  // Slot of each level-3 source; index five is the reset slot.
  function automatic logic [7:0] level3_offset(input logic [`IVM_IDX_W-1:0] idx);
    case (idx)
      6'd0: level3_offset = `OFF_STACK;
      6'd1: level3_offset = `OFF_ILLEGAL;
      6'd2: level3_offset = `OFF_DEBUG;
      6'd3: level3_offset = `OFF_TRAP;
      6'd4: level3_offset = `OFF_NMI;
      6'd5: level3_offset = `OFF_RESET;
      // Any other index lands on a reserved slot and is refused.
      default: level3_offset = `OFF_L3_RSV_A;
    endcase
  endfunction

  // True for any slot that has no source behind it.
  // Odd offsets lie inside a two-word slot, so they never start one.
  function automatic logic slot_reserved(input logic [7:0] off);
    slot_reserved = off[0] ||
      off == `OFF_L3_RSV_A || off == `OFF_L3_RSV_B ||
      off == `OFF_RSV_A || off == `OFF_RSV_B ||
      off == `OFF_DAX_RSV || off == `OFF_SHP_RSV ||
      (off >= `OFF_RSV_LO && off <= `OFF_RSV_HI) ||
      (off >= `OFF_RSV2_LO && off <= `OFF_RSV2_HI) ||
      off >= `OFF_RSV_TOP;
  endfunction

  // Slots are 256 words apart at most, so the base supplies only the
  // upper bits; its low byte is ignored rather than added, which keeps
  // the path a plain concatenation with no carry.
  function automatic logic [`IVM_ADDR_W-1:0] vector_addr(
    input logic [`IVM_ADDR_W-1:0] base,
    input logic [7:0] off
  );
    vector_addr = {base[`IVM_ADDR_W-1:8], off};
  endfunction

  // Highest enabled level among pending maskable sources. A field of
  // zero never wins, so a disabled source is invisible.
  always_comb begin
    best_field = 2'h0;
    for (int i = 0; i < `IVM_NUM_SRC; i++) begin
      if (source_req[i] && priority_level[i] > best_field) begin
        best_field = priority_level[i];
      end
    end
  end

  // First source in service order at the winning level.
  // Scanning from the bottom lets the lowest index overwrite the rest.
  always_comb begin
    sel_found = 1'b0;
    sel_idx = '0;
    for (int i = `IVM_NUM_SRC - 1; i >= 0; i--) begin
      if (source_req[i] && best_field != 2'h0 &&
          priority_level[i] == best_field) begin
        sel_found = 1'b1;
        sel_idx = 6'(i);
      end
    end
  end

  // Level-3 requests cannot be masked and beat every maskable source.
  // Bit 0 is the highest, so the stack error outranks the rest.
  always_comb begin
    l3_found = 1'b0;
    l3_idx = '0;
    for (int i = `IVM_NUM_L3 - 1; i >= 0; i--) begin
      if (level3_req[i]) begin
        l3_found = 1'b1;
        l3_idx = 6'(i);
      end
    end
  end

  // A maskable winner goes out only at or above the sequencer's mask level and
  // only if its slot is a real one.
  assign maskable_ok = sel_found && best_field > core_mask &&
    !slot_reserved(maskable_offset(sel_idx));

  // Pending summary for the sequencer. It ignores the mask on purpose, so
  // software can see what waits even while the core holds its level high.
  always_comb begin
    if (l3_found) begin
      pend_code = 2'h3;
    end else if (best_field != 2'h0) begin
      pend_code = 2'(best_field - 2'h1);
    end else begin
      pend_code = 2'h0;
    end
  end

  // The offered request must still stand; the reset offer always does.
  // An index past the table reads as gone rather than as an unknown,
  // which would otherwise leave the offer hanging.
  always_comb begin
    still_pending = 1'b0;
    if (!r.offer.level3) begin
      if (r.offer.source < 6'(`IVM_NUM_SRC)) begin
        still_pending = source_req[r.offer.source];
      end
    end else if (r.offer.source == `IVM_BOOT_IDX) begin
      still_pending = 1'b1;
    end else if (r.offer.source < 6'(`IVM_NUM_L3)) begin
      still_pending = level3_req[r.offer.source[2:0]];
    end
  end

  // Next-state logic: boot offer, idle arbitration, held offer, ack gap.
  always_comb begin
    next_r = r;
    next_r.ack = '0;
    next_r.l3_ack = '0;
    next_r.pend_any = l3_found || best_field != 2'h0;
    next_r.pend_level = pend_code;
    case (r.state)
      ivm_pkg::ST_BOOT: begin
        // After reset the sequencer first fetches the reset slot.
        next_r.offer.valid = 1'b1;
        next_r.offer.addr = vector_addr(vector_base, `OFF_RESET);
        next_r.offer.level = 2'h3;
        next_r.offer.level3 = 1'b1;
        next_r.offer.source = `IVM_BOOT_IDX;
        next_r.state = ivm_pkg::ST_OFFER;
      end
      ivm_pkg::ST_IDLE: begin
        // Level-3 first, then the best maskable source at or above the mask.
        if (l3_found && !slot_reserved(level3_offset(l3_idx))) begin
          next_r.offer.valid = 1'b1;
          next_r.offer.addr = vector_addr(vector_base, level3_offset(l3_idx));
          next_r.offer.level = 2'h3;
          next_r.offer.level3 = 1'b1;
          next_r.offer.source = l3_idx;
          next_r.state = ivm_pkg::ST_OFFER;
        end else if (maskable_ok) begin
          next_r.offer.valid = 1'b1;
          next_r.offer.addr = vector_addr(vector_base, maskable_offset(sel_idx));
          next_r.offer.level = 2'(best_field - 2'h1);
          next_r.offer.level3 = 1'b0;
          next_r.offer.source = sel_idx;
          next_r.state = ivm_pkg::ST_OFFER;
        end
      end
      ivm_pkg::ST_OFFER: begin
        // The offer is held steady; a later, higher request waits for the
        // next round so the sequencer never sees the address change.
        if (vector_taken) begin
          next_r.offer.valid = 1'b0;
          next_r.state = ivm_pkg::ST_ACK;
          // The reset offer has no source behind it and is not acknowledged.
          if (!r.offer.level3) begin
            next_r.ack[r.offer.source] = 1'b1;
          end else if (r.offer.source != `IVM_BOOT_IDX) begin
            next_r.l3_ack[r.offer.source[2:0]] = 1'b1;
          end
        end else if (!still_pending) begin
          next_r.offer.valid = 1'b0;
          next_r.state = ivm_pkg::ST_IDLE;
        end
      end
      ivm_pkg::ST_ACK: begin
        // One gap cycle lets the source drop its request before we look.
        next_r.state = ivm_pkg::ST_IDLE;
      end
      default: begin
        // An unused state code falls back to idle with no offer.
        next_r.offer.valid = 1'b0;
        next_r.state = ivm_pkg::ST_IDLE;
      end
    endcase
  end

  // All state in one register; the all-zero value is the boot state.
  // Reset is synchronous, so the first edge after release makes the boot offer.
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a flip-flop.
  // The acknowledges are one-cycle pulses; a source must drop its request then.
  assign vector_offer = r.offer;
  assign source_ack = r.ack;
  assign level3_ack = r.l3_ack;
  assign pending_level = r.pend_level;
  assign pending_any = r.pend_any;

endmodule // interrupt_vector_map

`default_nettype wire

/* ivm_seq_model.sv */
// Sequencer stand-in: takes each standing vector offer after a stall.
// Assumes the map holds its offer steady until it is taken or withdrawn, as its handshake allows.
`timescale 1ns/1ps
`default_nettype none
module ivm_seq_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Offer from the map and the stall before taking it.
  input wire ivm_pkg::vector_offer_s vector_offer,
  input wire logic [3:0] stall,
  // Acceptance pulse.
  output logic vector_taken
);
  logic [3:0] wait_cnt;

  // One pulse per offer; the pulse clears itself so an offer is never taken twice.
  always_ff @(posedge clk) begin
    if (reset || !vector_offer.valid || vector_taken) begin
      wait_cnt <= 4'h0;
      vector_taken <= 1'b0;
    end else if (wait_cnt == stall) begin
      vector_taken <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // ivm_seq_model
`default_nettype wire

/* ivm_checker.sv */
// Checker for the interrupt vector map: slots, masking and acknowledges.
// Assumes vector base and core mask stay steady while an offer stands.
`timescale 1ns/1ps
`default_nettype none
module ivm_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Inputs of the map.
  input wire logic [23:0] vector_base,
  input wire logic [1:0] core_mask,
  input wire logic [4:0] level3_req,
  input wire logic [43:0] source_req,
  input wire logic [43:0][1:0] priority_level,
  input wire logic vector_taken,
  // Outputs of the map.
  input wire ivm_pkg::vector_offer_s vector_offer,
  input wire logic [43:0] source_ack,
  input wire logic [4:0] level3_ack,
  input wire logic [1:0] pending_level,
  input wire logic pending_any
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] off;

  // Slot offset of the standing offer.
  assign off = vector_offer.addr[7:0];

  sequence s_take;
    vector_offer.valid && vector_taken;
  endsequence
  sequence s_new_masked;
    $rose(vector_offer.valid) && !vector_offer.level3;
  endsequence

  a_base_used: assert property (
    vector_offer.valid |-> vector_offer.addr[23:8] == vector_base[23:8] && !off[0])
    else $error("offer address not on base");
  a_l3_slot: assert property (vector_offer.valid && vector_offer.level3 |->
    off == (vector_offer.source == 6'h05 ? 8'h00 : {1'b0, vector_offer.source + 6'h01, 1'b0}))
    else $error("level-3 slot wrong");
  a_no_reserved: assert property (vector_offer.valid && !vector_offer.level3 |->
    !(off inside {8'h24, 8'h26, 8'h2c, 8'h46, [8'h4e:8'h52], [8'h66:8'h6e]}) && off < 8'h80)
    else $error("reserved slot offered");
  a_field_level: assert property (vector_offer.valid && !vector_offer.level3 |->
    priority_level[vector_offer.source] == vector_offer.level + 2'h1)
    else $error("offered level differs from field");
  a_mask_kept: assert property (s_new_masked |-> vector_offer.level >= core_mask)
    else $error("masked source offered");
  a_l3_first: assert property (s_new_masked |-> $past(level3_req) == 5'h0 &&
    source_req[vector_offer.source])
    else $error("offer beside pending level-3");
  a_ack_source: assert property (s_take ##0 !vector_offer.level3 |=>
    !vector_offer.valid && source_ack == (44'h1 << $past(vector_offer.source)))
    else $error("wrong source acknowledged");
  a_l3_ack: assert property (s_take ##0 vector_offer.level3 |=>
    source_ack == 44'h0 && level3_ack == ($past(vector_offer.source) == 6'h05 ? 5'h0 :
    5'h1 << $past(vector_offer.source[2:0])))
    else $error("wrong level-3 acknowledge");
  a_ack_gap: assert property ((|source_ack) || (|level3_ack) |=> !vector_offer.valid)
    else $error("offer right after acknowledge");
  a_pend_l3: assert property (level3_req != 5'h0 |=> pending_any && pending_level == 2'h3)
    else $error("level-3 not pending");
endmodule // ivm_checker

bind interrupt_vector_map ivm_checker chk (.clk(clk), .reset(reset),
  .vector_base(vector_base), .core_mask(core_mask), .level3_req(level3_req),
  .source_req(source_req), .priority_level(priority_level), .vector_taken(vector_taken),
  .vector_offer(vector_offer), .source_ack(source_ack), .level3_ack(level3_ack),
  .pending_level(pending_level), .pending_any(pending_any));
`default_nettype wire

/* tb_top.sv */
// Testbench for the interrupt vector map with a sequencer model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [23:0] vector_base = 24'h3a_5c17;
  logic [1:0] core_mask = 2'h0;
  logic [4:0] level3_req = 5'h0;
  logic [43:0] source_req = '0;
  logic [43:0][1:0] priority_level = '0;
  logic [3:0] stall = 4'h0;
  logic vector_taken;
  ivm_pkg::vector_offer_s vector_offer;
  logic [43:0] source_ack;
  logic [4:0] level3_ack;
  logic [1:0] pending_level;
  logic pending_any;
  int bad_count = 0;
  int checked = 0;
  // Expected slot of each source in service order.
  logic [7:0] slot [44] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20,
    8'h22, 8'h34, 8'h32, 8'h30, 8'h36, 8'h3c, 8'h3e, 8'h3a, 8'h38, 8'h4c, 8'h4a, 8'h42,
    8'h48, 8'h40, 8'h44, 8'h64, 8'h60, 8'h62, 8'h28, 8'h2a, 8'h2e, 8'h56, 8'h54, 8'h5a,
    8'h58, 8'h5e, 8'h5c, 8'h74, 8'h72, 8'h70, 8'h76, 8'h7c, 8'h7e, 8'h7a, 8'h78};

  interrupt_vector_map dut (.clk(clk), .reset(reset), .vector_base(vector_base),
    .core_mask(core_mask), .level3_req(level3_req), .source_req(source_req),
    .priority_level(priority_level), .vector_offer(vector_offer),
    .vector_taken(vector_taken), .source_ack(source_ack), .level3_ack(level3_ack),
    .pending_level(pending_level), .pending_any(pending_any));
  ivm_seq_model seq (.clk(clk), .reset(reset), .vector_offer(vector_offer),
    .stall(stall), .vector_taken(vector_taken));

  // Clock at 10 MHz.
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait step; running out counts as a mismatch and ends the run.
  task automatic step(inout int n);
    n++;
    if (n > 40) begin
      bad_count++;
      wrap_up();
    end else begin
      tick(1);
    end
  endtask

  // Waits for the offer, checks it, then, except for the reset offer, checks the acknowledge and drops the request.
  task automatic take(input logic [7:0] off, input logic [1:0] lvl, input logic l3,
      input logic [5:0] src);
    int n;
    n = 0;
    while (vector_offer.valid !== 1'b1) step(n);
    `CHK(vector_offer, {1'b1, vector_base[23:8], off, lvl, l3, src})
    if (l3 && src == 6'h05) begin
      while (vector_offer.valid === 1'b1) step(n);
      return;
    end
    while (!(|{level3_ack, source_ack})) step(n);
    `CHK({level3_ack, source_ack}, 49'h1 << (l3 ? 44 + src : src))
    if (l3) level3_req[src] = 1'b0;
    else source_req[src] = 1'b0;
    tick(1);
  endtask

  // Every source alone at level 0 must land on its own slot.
  task automatic sweep_slots();
    for (int i = 0; i < 44; i++) begin
      stall = 4'(i % 3);
      priority_level[i] = 2'h1;
      source_req[i] = 1'b1;
      take(slot[i], 2'h0, 1'b0, 6'(i));
      priority_level[i] = 2'h0;
    end
  endtask

  // Level-3 sources on a new base whose low byte must be ignored.
  task automatic level3_slots();
    vector_base = 24'hc4_09ff;
    for (int i = 0; i < 5; i++) begin
      level3_req[i] = 1'b1;
      take(8'(2 * i + 2), 2'h3, 1'b1, 6'(i));
    end
  endtask

  // Same level served in list order, pins before the last audio source.
  task automatic same_level_order();
    priority_level[0] = 2'h2;
    priority_level[20] = 2'h2;
    priority_level[43] = 2'h2;
    source_req = 44'h800_0010_0001;
    take(slot[0], 2'h1, 1'b0, 6'd0);
    take(slot[20], 2'h1, 1'b0, 6'd20);
    take(slot[43], 2'h1, 1'b0, 6'd43);
    priority_level = '0;
  endtask

  // Higher field wins; disabled and masked sources are refused.
  task automatic levels_and_mask();
    priority_level[7] = 2'h1;
    priority_level[30] = 2'h3;
    source_req = 44'h0_4000_0088;
    take(slot[30], 2'h2, 1'b0, 6'd30);
    core_mask = 2'h2;
    tick(6);
    `CHK(vector_offer.valid, 1'b0)
    source_req[30] = 1'b1;
    core_mask = 2'h3;
    tick(6);
    `CHK(vector_offer.valid, 1'b0)
    `CHK({pending_any, pending_level}, 3'h6)
    level3_req[4] = 1'b1;
    take(8'h0a, 2'h3, 1'b1, 6'd4);
    core_mask = 2'h0;
    take(slot[30], 2'h2, 1'b0, 6'd30);
    take(slot[7], 2'h0, 1'b0, 6'd7);
    tick(6);
    `CHK(vector_offer.valid, 1'b0)
    source_req = '0;
  endtask

  // Level equal to the mask is served, one below waits; a dropped request withdraws.
  task automatic mask_edge_withdraw();
    int n;
    n = 0;
    core_mask = 2'h1;
    priority_level[25] = 2'h1;
    priority_level[26] = 2'h2;
    source_req[26:25] = 2'h3;
    stall = 4'hf;
    while (vector_offer.valid !== 1'b1) step(n);
    `CHK(vector_offer, {1'b1, vector_base[23:8], slot[26], 2'h1, 1'b0, 6'd26})
    tick(1);
    source_req[26] = 1'b0;
    tick(2);
    `CHK({vector_offer.valid, source_ack}, 45'h0)
    source_req[25] = 1'b0;
    priority_level = '0;
    core_mask = 2'h0;
    stall = 4'h0;
  endtask

  // Main sequence.
  initial begin
    tick(6);
    reset = 1'b0;
    take(8'h00, 2'h3, 1'b1, 6'h05);
    sweep_slots();
    level3_slots();
    same_level_order();
    levels_and_mask();
    mask_edge_withdraw();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
